// file: core/tlus_consts.svh
/*
 Timing and code constants for the tape load/unload sequencer.
 Assumes a 100 MHz system clock; included by bare name.
*/
`ifndef TLUS_CONSTS_SVH
`define TLUS_CONSTS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define TLUS_CLK_NS 10
`define TLUS_HUB_SWING_US 1000
`define TLUS_HUB_SWING_CYC ((`TLUS_HUB_SWING_US * 1000) / `TLUS_CLK_NS)

// ----------------------------------------
// Reel size codes
// ----------------------------------------
`define TLUS_REEL_NONE 2'h0
`define TLUS_REEL_SMALL 2'h1
`define TLUS_REEL_MEDIUM 2'h2
`define TLUS_REEL_LARGE 2'h3

// ----------------------------------------
// Fault codes
// ----------------------------------------
`define TLUS_FAULT_NONE 4'h0
`define TLUS_FAULT_CLAMP 4'h1
`define TLUS_FAULT_THREAD 4'h2
`define TLUS_FAULT_SIZE 4'h3
`define TLUS_FAULT_MARKER 4'h4
`define TLUS_FAULT_DENSITY 4'h5
`define TLUS_FAULT_REWIND 4'h6
`define TLUS_FAULT_UNCLAMP 4'h7

`endif

// file: core/tlus_pkg.sv
/*
 Types for the tape load/unload sequencer.
 Assumes nothing of its surroundings.
*/
package tlus_pkg;
    typedef enum logic [4:0] {
        ST_HEALTH = 5'h00,
        ST_CENTER = 5'h01,
        ST_NOTAPE = 5'h02,
        ST_WAITREEL = 5'h03,
        ST_CLAMP = 5'h04,
        ST_THREAD = 5'h05,
        ST_SIZE = 5'h06,
        ST_MARKER = 5'h07,
        ST_DENSITY = 5'h08,
        ST_OFFLINE = 5'h09,
        ST_ONLINE = 5'h0A,
        ST_DRAIN = 5'h0B,
        ST_COVER = 5'h0C,
        ST_REWIND = 5'h0D,
        ST_UNCLAMP = 5'h0E,
        ST_DOOR = 5'h0F,
        ST_READY = 5'h10,
        ST_CANCEL = 5'h11,
        ST_FAULT = 5'h12,
        ST_DIAGNOSTIC_MODE_BUTTON = 5'h13
    } tlus_state_e;
endpackage : tlus_pkg

// file: core/tlus_sequencer.sv
/*
 Load/unload sequencer for a reel-to-reel tape unit: front panel buttons,
 door and cover sensors, mechanism start/done handshakes, host online flag.
 Assumes buttons are debounced single-cycle-or-level inputs synchronous to clock,
 and that each mechanism reports done or fail while its start command is held.
*/
// What this block does
// - Cover open while online or draining: offline, halt motion.
// - Return online needs cover secured, load press.
// - After health check, centre reel swinging hub.
// - No reel: no-tape indication, prompt, wait.
// - Reel present: continue to clamping automatically.
// - Waiting for reel: reset press opens door.
// - Load steps run in fixed order.
// - Classify reel small, medium, large; show it.
// - Host online only after marker reached.
// - At marker offline, load press goes online.
// - Reset then load press cancels unload.
// - Reset goes offline; diagnostic_mode_button button leaves diagnostics.
// - Offline may wait for buffered data drain.
// - Reset held plus rewind press: rewind, unclamp, door.
// - Unload done shows ready indication.
// - Threaded tape at power-on loads automatically.
// - No load until door and cover closed.
`timescale 1ns/1ps
`default_nettype none
`include "tlus_consts.svh"

module tlus_sequencer #(
    parameter int unsigned HUB_SWING_CYC = `TLUS_HUB_SWING_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic healthOk,
    input wire logic healthFail,
    input wire logic loadOnlineButton,
    input wire logic resetButton,
    input wire logic rewindUnloadButton,
    input wire logic diagnosticModeButton,
    input wire logic diagRequest,
    input wire logic doorClosed,
    input wire logic coverClosed,
    input wire logic reelSensed,
    input wire logic tapeThreaded,
    input wire logic bufferBusy,
    input wire logic stageDone,
    input wire logic stageFail,
    input wire logic [1:0] reelSizeIn,
    input wire logic markerSeen,
    output logic hubForward,
    output logic hubReverse,
    output logic clampCmd,
    output logic threadCmd,
    output logic sizeCmd,
    output logic markerSearchCmd,
    output logic densityCmd,
    output logic rewindCmd,
    output logic unclampCmd,
    output logic doorRelease,
    output logic motionEnable,
    output logic hostOnline,
    output logic noTapeIndication,
    output logic loadPrompt,
    output logic readyIndication,
    output logic rewindUnloadIndication,
    output logic diagIndication,
    output logic markerIndication,
    output logic [1:0] reelClass,
    output logic [3:0] faultCode,
    output logic [4:0] seqState
);
    tlus_pkg::tlus_state_e state_reg, state_next;
    logic [31:0] swing_reg, swing_next;
    logic hubDir_reg, hubDir_next;
    logic [1:0] reel_reg, reel_next;
    logic [3:0] fault_reg, fault_next;
    logic tensioned_reg, tensioned_next;
    logic cancelArm_reg, cancelArm_next;
    logic closed;
    assign closed = doorClosed && coverClosed;

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        swing_next = swing_reg;
        hubDir_next = hubDir_reg;
        reel_next = reel_reg;
        fault_next = fault_reg;
        tensioned_next = tensioned_reg;
        cancelArm_next = cancelArm_reg;
        case (state_reg)
            tlus_pkg::ST_HEALTH: begin
                if (healthFail) begin
                    fault_next = `TLUS_FAULT_CLAMP;
                    state_next = tlus_pkg::ST_FAULT;
                end else if (healthOk && tapeThreaded && closed) begin
                    state_next = tlus_pkg::ST_CLAMP;
                end else if (healthOk) begin
                    state_next = tlus_pkg::ST_CENTER;
                    swing_next = 32'h0;
                end
            end
            tlus_pkg::ST_CENTER: begin
                if (swing_reg >= HUB_SWING_CYC - 1) begin
                    swing_next = 32'h0;
                    hubDir_next = !hubDir_reg;
                    if (hubDir_reg) begin
                        if (reelSensed && closed) begin
                            state_next = tlus_pkg::ST_CLAMP;
                        end else if (!reelSensed) begin
                            state_next = tlus_pkg::ST_NOTAPE;
                        end
                    end
                end else begin
                    swing_next = swing_reg + 32'h1;
                end
            end
            tlus_pkg::ST_NOTAPE: state_next = tlus_pkg::ST_WAITREEL;
            tlus_pkg::ST_WAITREEL, tlus_pkg::ST_READY: begin
                if (loadOnlineButton && closed) begin
                    state_next = tlus_pkg::ST_CENTER;
                    swing_next = 32'h0;
                end
            end
            tlus_pkg::ST_CLAMP: begin
                if (stageFail) begin
                    fault_next = `TLUS_FAULT_CLAMP;
                    state_next = tlus_pkg::ST_FAULT;
                end else if (stageDone) begin
                    state_next = tlus_pkg::ST_THREAD;
                end
            end
            tlus_pkg::ST_THREAD: begin
                if (stageFail) begin
                    fault_next = `TLUS_FAULT_THREAD;
                    state_next = tlus_pkg::ST_FAULT;
                end else if (stageDone) begin
                    tensioned_next = 1'b1;
                    state_next = tlus_pkg::ST_SIZE;
                end
            end
            tlus_pkg::ST_SIZE: begin
                if (stageFail || (stageDone && reelSizeIn == `TLUS_REEL_NONE)) begin
                    fault_next = `TLUS_FAULT_SIZE;
                    state_next = tlus_pkg::ST_FAULT;
                end else if (stageDone) begin
                    reel_next = reelSizeIn;
                    state_next = tlus_pkg::ST_MARKER;
                end
            end
            tlus_pkg::ST_MARKER: begin
                if (stageFail) begin
                    fault_next = `TLUS_FAULT_MARKER;
                    state_next = tlus_pkg::ST_FAULT;
                end else if (markerSeen) begin
                    state_next = tlus_pkg::ST_DENSITY;
                end
            end
            tlus_pkg::ST_DENSITY: begin
                if (stageFail) begin
                    fault_next = `TLUS_FAULT_DENSITY;
                    state_next = tlus_pkg::ST_FAULT;
                end else if (stageDone) begin
                    state_next = tlus_pkg::ST_OFFLINE;
                end
            end
            tlus_pkg::ST_OFFLINE: begin
                if (resetButton && rewindUnloadButton) begin
                    cancelArm_next = 1'b0;
                    state_next = tlus_pkg::ST_REWIND;
                end else if (diagRequest) begin
                    state_next = tlus_pkg::ST_DIAGNOSTIC_MODE_BUTTON;
                end else if (loadOnlineButton && coverClosed) begin
                    state_next = tlus_pkg::ST_ONLINE;
                end
            end
            tlus_pkg::ST_ONLINE: begin
                if (!coverClosed) begin
                    state_next = tlus_pkg::ST_COVER;
                end else if (resetButton) begin
                    state_next = tlus_pkg::ST_DRAIN;
                end else if (diagRequest) begin
                    state_next = tlus_pkg::ST_DIAGNOSTIC_MODE_BUTTON;
                end
            end
            tlus_pkg::ST_DRAIN: begin
                if (!coverClosed) begin
                    state_next = tlus_pkg::ST_COVER;
                end else if (!bufferBusy) begin
                    state_next = tlus_pkg::ST_OFFLINE;
                end
            end
            tlus_pkg::ST_DIAGNOSTIC_MODE_BUTTON: begin
                if (diagnosticModeButton) begin
                    state_next = tlus_pkg::ST_OFFLINE;
                end
            end
            tlus_pkg::ST_COVER: begin
                if (coverClosed && loadOnlineButton) begin
                    state_next = tlus_pkg::ST_ONLINE;
                end
            end
            tlus_pkg::ST_REWIND, tlus_pkg::ST_UNCLAMP: begin
                if (resetButton) begin
                    cancelArm_next = 1'b1;
                end
                if (cancelArm_reg && loadOnlineButton) begin
                    cancelArm_next = 1'b0;
                    state_next = tlus_pkg::ST_CANCEL;
                end else if (stageFail) begin
                    fault_next = (state_reg == tlus_pkg::ST_REWIND) ?
                        `TLUS_FAULT_REWIND : `TLUS_FAULT_UNCLAMP;
                    state_next = tlus_pkg::ST_FAULT;
                end else if (stageDone) begin
                    if (state_reg == tlus_pkg::ST_REWIND) begin
                        state_next = tlus_pkg::ST_UNCLAMP;
                    end else begin
                        tensioned_next = 1'b0;
                        reel_next = `TLUS_REEL_NONE;
                        state_next = tlus_pkg::ST_DOOR;
                    end
                end
            end
            tlus_pkg::ST_CANCEL: state_next = tlus_pkg::ST_MARKER;
            tlus_pkg::ST_DOOR: state_next = tlus_pkg::ST_READY;
            tlus_pkg::ST_FAULT: state_next = tlus_pkg::ST_FAULT;
            default: state_next = tlus_pkg::ST_HEALTH;
        endcase
    end

    // ----------------------------------------
    // State registers
    // ----------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= tlus_pkg::ST_HEALTH;
            swing_reg <= 32'h0;
            hubDir_reg <= 1'b0;
            reel_reg <= `TLUS_REEL_NONE;
            fault_reg <= `TLUS_FAULT_NONE;
            tensioned_reg <= 1'b0;
            cancelArm_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            swing_reg <= swing_next;
            hubDir_reg <= hubDir_next;
            reel_reg <= reel_next;
            fault_reg <= fault_next;
            tensioned_reg <= tensioned_next;
            cancelArm_reg <= cancelArm_next;
        end
    end

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hubForward <= 1'b0;
            hubReverse <= 1'b0;
            clampCmd <= 1'b0;
            threadCmd <= 1'b0;
            sizeCmd <= 1'b0;
            markerSearchCmd <= 1'b0;
            densityCmd <= 1'b0;
            rewindCmd <= 1'b0;
            unclampCmd <= 1'b0;
            doorRelease <= 1'b0;
            motionEnable <= 1'b0;
            hostOnline <= 1'b0;
            noTapeIndication <= 1'b0;
            loadPrompt <= 1'b0;
            readyIndication <= 1'b0;
            rewindUnloadIndication <= 1'b0;
            diagIndication <= 1'b0;
            markerIndication <= 1'b0;
            reelClass <= `TLUS_REEL_NONE;
            faultCode <= `TLUS_FAULT_NONE;
            seqState <= 5'h00;
        end else begin
            hubForward <= state_next == tlus_pkg::ST_CENTER && !hubDir_next;
            hubReverse <= state_next == tlus_pkg::ST_CENTER && hubDir_next;
            clampCmd <= state_next == tlus_pkg::ST_CLAMP;
            threadCmd <= state_next == tlus_pkg::ST_THREAD;
            sizeCmd <= state_next == tlus_pkg::ST_SIZE;
            markerSearchCmd <= state_next == tlus_pkg::ST_MARKER;
            densityCmd <= state_next == tlus_pkg::ST_DENSITY;
            rewindCmd <= state_next == tlus_pkg::ST_REWIND;
            unclampCmd <= state_next == tlus_pkg::ST_UNCLAMP;
            doorRelease <= (state_reg == tlus_pkg::ST_WAITREEL && resetButton) ||
                state_next == tlus_pkg::ST_DOOR;
            motionEnable <= state_next == tlus_pkg::ST_ONLINE ||
                state_next == tlus_pkg::ST_DRAIN;
            hostOnline <= state_next == tlus_pkg::ST_ONLINE ||
                state_next == tlus_pkg::ST_DRAIN;
            noTapeIndication <= state_next == tlus_pkg::ST_NOTAPE;
            loadPrompt <= state_next == tlus_pkg::ST_WAITREEL;
            readyIndication <= state_next == tlus_pkg::ST_READY;
            rewindUnloadIndication <= state_next == tlus_pkg::ST_REWIND ||
                state_next == tlus_pkg::ST_UNCLAMP || state_next == tlus_pkg::ST_DOOR;
            diagIndication <= state_next == tlus_pkg::ST_DIAGNOSTIC_MODE_BUTTON ||
                state_next == tlus_pkg::ST_HEALTH;
            markerIndication <= state_next == tlus_pkg::ST_OFFLINE ||
                state_next == tlus_pkg::ST_ONLINE;
            reelClass <= reel_next;
            faultCode <= fault_next;
            seqState <= state_next;
        end
    end

endmodule : tlus_sequencer
`default_nettype wire

// file: tb/tlus_sequencer_chk.sv
/*
 Checker for the tape load/unload sequencer, bound to its ports.
 Assumes the state codes of the package and an active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module tlus_sequencer_chk #(
    parameter int unsigned HUB_SWING_CYC = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic loadOnlineButton,
    input wire logic resetButton,
    input wire logic rewindUnloadButton,
    input wire logic diagRequest,
    input wire logic doorClosed,
    input wire logic coverClosed,
    input wire logic bufferBusy,
    input wire logic hubForward,
    input wire logic hubReverse,
    input wire logic clampCmd,
    input wire logic threadCmd,
    input wire logic markerSearchCmd,
    input wire logic densityCmd,
    input wire logic hostOnline,
    input wire logic motionEnable,
    input wire logic [3:0] faultCode,
    input wire logic [4:0] seqState
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_online_at_marker: assert property (
        hostOnline |-> (seqState == tlus_pkg::ST_ONLINE || seqState == tlus_pkg::ST_DRAIN))
        else $error("host online outside the online states");
    a_cover_drops_online: assert property (
        (seqState == tlus_pkg::ST_ONLINE && !coverClosed) |=> !hostOnline && !motionEnable)
        else $error("cover open left the unit online");
    a_hub_one_way: assert property (!(hubForward && hubReverse))
        else $error("hub driven both ways");
    a_load_needs_closed: assert property (
        $rose(clampCmd) |-> $past(doorClosed && coverClosed))
        else $error("clamping began with door or cover open");
    a_press_goes_online: assert property (
        (seqState == tlus_pkg::ST_OFFLINE && loadOnlineButton && coverClosed && !resetButton
        && !rewindUnloadButton && !diagRequest) |=> hostOnline)
        else $error("load press at marker did not go online");
    a_reset_goes_offline: assert property (
        (seqState == tlus_pkg::ST_DRAIN && !bufferBusy && coverClosed) |=> !hostOnline)
        else $error("reset press did not go offline");
    a_drain_keeps_online: assert property (
        (seqState == tlus_pkg::ST_DRAIN && bufferBusy && coverClosed) |=> hostOnline)
        else $error("went offline with buffered data");
    a_thread_after_clamp: assert property ($rose(threadCmd) |-> $past(clampCmd))
        else $error("threading did not follow clamping");
    a_density_after_bot: assert property ($rose(densityCmd) |-> $past(markerSearchCmd))
        else $error("density step did not follow marker search");
    a_fault_held: assert property ((faultCode != 4'h0) |=> $stable(faultCode))
        else $error("fault code changed before reset");
endmodule : tlus_sequencer_chk

bind tlus_sequencer tlus_sequencer_chk #(.HUB_SWING_CYC(HUB_SWING_CYC)) chk_u (
    .clock(clock), .rst(rst), .loadOnlineButton(loadOnlineButton),
    .resetButton(resetButton), .rewindUnloadButton(rewindUnloadButton),
    .diagRequest(diagRequest), .doorClosed(doorClosed), .coverClosed(coverClosed),
    .bufferBusy(bufferBusy), .hubForward(hubForward), .hubReverse(hubReverse),
    .clampCmd(clampCmd), .threadCmd(threadCmd), .markerSearchCmd(markerSearchCmd),
    .densityCmd(densityCmd), .hostOnline(hostOnline), .motionEnable(motionEnable),
    .faultCode(faultCode), .seqState(seqState)
);

`default_nettype wire

// file: tb/tlus_mech_model.sv
/*
 Mechanism model: answers each stage command after a short delay.
 Assumes commands are held until done or fail is seen.
*/
`timescale 1ns/1ps
`default_nettype none

module tlus_mech_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic [6:0] cmds,
    input wire logic failThread,
    output logic stageDone,
    output logic stageFail,
    output logic markerSeen
);
    logic [3:0] count_reg;
    logic [3:0] count_next;
    logic busy;
    logic fin;

    assign busy = |cmds;
    assign fin = busy && (count_reg == (cmds[5] ? 4'hC : 4'h3));
    assign stageDone = fin && !(failThread && cmds[1]);
    assign stageFail = fin && failThread && cmds[1];
    assign markerSeen = fin && cmds[3];

    always_comb begin
        count_next = (busy && !fin) ? count_reg + 4'h1 : 4'h0;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_reg <= 4'h0;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule : tlus_mech_model

`default_nettype wire

// file: tb/tlus_sequencer_tb.sv
/*
 Self-checking bench for the tape load/unload sequencer.
 Assumes the mechanism model and a short hub swing of 4 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tlus_consts.svh"

module tlus_sequencer_tb;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic healthOk = 1'b0, diagRequest = 1'b0, doorClosed = 1'b1, coverClosed = 1'b1;
    logic healthFail = 1'b0;
    logic reelSensed = 1'b0, tapeThreaded = 1'b0, bufferBusy = 1'b0, failThread = 1'b0;
    logic [3:0] btn = 4'h0;
    logic [1:0] reelSizeIn = `TLUS_REEL_MEDIUM;
    logic stageDone, stageFail, markerSeen, hubForward, hubReverse, doorRelease;
    logic clampCmd, threadCmd, sizeCmd, markerSearchCmd, densityCmd, rewindCmd, unclampCmd;
    logic motionEnable, hostOnline, noTapeIndication, loadPrompt, readyIndication;
    logic rewindUnloadIndication, diagIndication, markerIndication;
    logic [1:0] reelClass;
    logic [3:0] faultCode;
    logic [4:0] seqState;
    int failures = 0;
    int comparisons = 0;

    always #5 clock = ~clock;

    tlus_sequencer #(.HUB_SWING_CYC(4)) dut_u (
        .clock(clock), .rst(rst), .healthOk(healthOk), .healthFail(healthFail),
        .loadOnlineButton(btn[1]), .resetButton(btn[0]), .rewindUnloadButton(btn[2]),
        .diagnosticModeButton(btn[3]), .diagRequest(diagRequest), .doorClosed(doorClosed),
        .coverClosed(coverClosed), .reelSensed(reelSensed), .tapeThreaded(tapeThreaded),
        .bufferBusy(bufferBusy), .stageDone(stageDone), .stageFail(stageFail),
        .reelSizeIn(reelSizeIn), .markerSeen(markerSeen), .hubForward(hubForward),
        .hubReverse(hubReverse), .clampCmd(clampCmd), .threadCmd(threadCmd),
        .sizeCmd(sizeCmd), .markerSearchCmd(markerSearchCmd), .densityCmd(densityCmd),
        .rewindCmd(rewindCmd), .unclampCmd(unclampCmd), .doorRelease(doorRelease),
        .motionEnable(motionEnable), .hostOnline(hostOnline),
        .noTapeIndication(noTapeIndication), .loadPrompt(loadPrompt),
        .readyIndication(readyIndication), .rewindUnloadIndication(rewindUnloadIndication),
        .diagIndication(diagIndication), .markerIndication(markerIndication),
        .reelClass(reelClass), .faultCode(faultCode), .seqState(seqState)
    );

    tlus_mech_model mech_u (
        .clock(clock), .rst(rst), .failThread(failThread),
        .cmds({unclampCmd, rewindCmd, densityCmd, markerSearchCmd, sizeCmd, threadCmd,
            clampCmd}),
        .stageDone(stageDone), .stageFail(stageFail), .markerSeen(markerSeen)
    );

    task chk(input bit ok, input string msg);
        comparisons++;
        if (!ok) begin
            failures++;
            $display("Error %0t: %s", $time, msg);
        end
    endtask : chk

    task waitState(input tlus_pkg::tlus_state_e s, input int lim);
        int n;
        n = 0;
        while (seqState !== s && n < lim) begin
            @(negedge clock);
            n++;
        end
        chk(seqState === s, "expected state not reached");
    endtask : waitState

    task press(input logic [3:0] mask);
        @(posedge clock) btn <= mask;
        @(posedge clock) btn <= 4'h0;
        @(negedge clock);
    endtask : press

    task boot(input logic thr, input logic reel);
        @(posedge clock);
        rst <= 1'b1;
        tapeThreaded <= thr;
        reelSensed <= reel;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock) healthOk <= 1'b1;
    endtask : boot

    task t_load;
        boot(1'b0, 1'b1);
        waitState(tlus_pkg::ST_CLAMP, 300); // reel clamps
        chk(hostOnline === 1'b0, "online before marker"); // withheld
        waitState(tlus_pkg::ST_OFFLINE, 300); // load order
        chk(reelClass === `TLUS_REEL_MEDIUM, "reel class"); // size shown
        chk(markerIndication === 1'b1, "marker not shown"); // rest at marker
    endtask : t_load

    task t_online;
        press(4'h2);
        chk(hostOnline === 1'b1 && motionEnable === 1'b1, "not online"); // press
        @(posedge clock) coverClosed <= 1'b0;
        repeat (2) @(negedge clock);
        chk(hostOnline === 1'b0 && motionEnable === 1'b0, "cover open"); // halt
        press(4'h2);
        chk(hostOnline === 1'b0, "online with cover open"); // refused
        @(posedge clock) coverClosed <= 1'b1;
        press(4'h2);
        chk(hostOnline === 1'b1, "no return online"); // restored
    endtask : t_online

    task t_offline;
        @(posedge clock) bufferBusy <= 1'b1;
        press(4'h1);
        repeat (3) @(negedge clock);
        chk(hostOnline === 1'b1, "offline while draining"); // drain wait
        @(posedge clock) bufferBusy <= 1'b0;
        waitState(tlus_pkg::ST_OFFLINE, 10); // reset offline
        chk(hostOnline === 1'b0, "still online"); // reset offline
    endtask : t_offline

    task t_unload;
        press(4'h5);
        waitState(tlus_pkg::ST_REWIND, 5); // rewind starts
        chk(rewindUnloadIndication === 1'b1, "no unload sign"); // indication
        waitState(tlus_pkg::ST_DOOR, 100); // unclamp and door
        chk(doorRelease === 1'b1, "door not opened at unload end"); // door opens
        waitState(tlus_pkg::ST_READY, 5); // ready follows
        chk(readyIndication === 1'b1, "no ready sign"); // ready shown
    endtask : t_unload

    task t_cancel;
        press(4'h2);
        waitState(tlus_pkg::ST_OFFLINE, 300); // reload closed
        press(4'h5);
        waitState(tlus_pkg::ST_REWIND, 5); // unload begins
        press(4'h1);
        press(4'h2);
        waitState(tlus_pkg::ST_MARKER, 20); // unload cancelled
        waitState(tlus_pkg::ST_OFFLINE, 50); // back at marker
    endtask : t_cancel

    task t_diagnostic_mode_button;
        @(posedge clock) diagRequest <= 1'b1;
        waitState(tlus_pkg::ST_DIAGNOSTIC_MODE_BUTTON, 10); // diagnostic_mode_button mode entered
        chk(diagIndication === 1'b1, "no diagnostic_mode_button sign"); // diagnostic_mode_button shown
        @(posedge clock) diagRequest <= 1'b0;
        press(4'h8);
        chk(diagIndication === 1'b0, "diagnostic_mode_button sign stays"); // diagnostic_mode_button exit
        chk(seqState === tlus_pkg::ST_OFFLINE, "diagnostic_mode_button exit state"); // diagnostic_mode_button exit
    endtask : t_diagnostic_mode_button

    task t_notape;
        boot(1'b0, 1'b0);
        waitState(tlus_pkg::ST_NOTAPE, 300); // no reel
        chk(noTapeIndication === 1'b1, "no no-tape sign"); // indication
        waitState(tlus_pkg::ST_WAITREEL, 5); // then waits
        chk(loadPrompt === 1'b1, "no prompt"); // prompt shown
        press(4'h1);
        chk(doorRelease === 1'b1, "door not released"); // door opens
        @(posedge clock) doorClosed <= 1'b0;
        reelSensed <= 1'b1;
        press(4'h2);
        chk(seqState === tlus_pkg::ST_WAITREEL, "load with door open"); // refused
        @(posedge clock) doorClosed <= 1'b1;
        press(4'h2);
        waitState(tlus_pkg::ST_CLAMP, 300); // clamps reel
    endtask : t_notape

    task t_thread;
        reelSizeIn <= `TLUS_REEL_LARGE;
        boot(1'b1, 1'b0);
        waitState(tlus_pkg::ST_CLAMP, 300); // auto clamp
        waitState(tlus_pkg::ST_MARKER, 100); // marker search
        waitState(tlus_pkg::ST_OFFLINE, 100); // rests loaded
        chk(reelClass === `TLUS_REEL_LARGE, "large reel class"); // size shown
    endtask : t_thread

    task t_fault;
        failThread <= 1'b1;
        boot(1'b0, 1'b1);
        waitState(tlus_pkg::ST_FAULT, 300); // stage stops
        chk(faultCode === `TLUS_FAULT_THREAD, "fault code"); // code shown
        chk(threadCmd === 1'b0, "thread still driven"); // stage stops
        failThread <= 1'b0;
        healthFail <= 1'b1;
        boot(1'b0, 1'b1);
        waitState(tlus_pkg::ST_FAULT, 10); // check must pass
        chk(faultCode === `TLUS_FAULT_CLAMP && hubForward === 1'b0, "health fault"); // code
    endtask : t_fault

    task close_out;
        $display("Comparisons %0d, failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (2) @(posedge clock);
        t_load();
        t_online();
        t_offline();
        t_unload();
        t_cancel();
        t_diagnostic_mode_button();
        t_notape();
        t_thread();
        t_fault();
        close_out();
    end

    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        close_out();
    end
endmodule : tlus_sequencer_tb

`default_nettype wire
